// ### core/stack_check_and_program_space_map.sv
`timescale 1ns/1ps
`default_nettype none

module stack_check_and_program_space_map
    import stack_map_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // Stack requests from the pipeline
    input wire logic push_in,
    input wire logic [15:0] push_data_in,
    input wire logic pop_in,
    input wire logic call_push_in,
    input wire logic exc_push_in,
    input wire logic [22:0] program_counter_in,
    input wire logic [7:0] status_low_byte_in,
    input wire logic sp_ea_valid_in,
    input wire logic [15:0] sp_ea_in,
    // Stack memory side
    output logic [15:0] stack_addr_out,
    output logic [15:0] stack_wdata_out,
    output logic stack_wr_out,
    output logic stack_rd_out,
    output logic [15:0] stack_pointer_out,
    output logic stack_trap_out,
    // Table requests
    input wire logic table_req_in,
    input wire logic table_write_in,
    input wire logic table_high_in,
    input wire logic table_byte_in,
    input wire logic [15:0] table_ea_in,
    input wire logic [15:0] table_wdata_in,
    output logic [15:0] table_rdata_out,
    output logic table_rvalid_out,
    output logic table_refused_out,
    // Data reads that may fall in the remapped window
    input wire logic data_rd_in,
    input wire logic [15:0] data_ea_in,
    output logic [15:0] remap_rdata_out,
    output logic remap_rvalid_out,
    output logic remap_stall_out,
    // Program memory side
    input wire logic [23:0] prog_rdata_in,
    output logic [23:0] prog_addr_out,
    output logic prog_rd_out,
    output logic prog_wr_out,
    output logic [23:0] prog_wdata_out,
    output logic [2:0] prog_wstrb_out,
    output logic prog_config_out
);

    // Whole state of the block
    typedef struct packed {
        logic [15:0] sp;             // Stack pointer
        logic [15:0] limit;          // Stack limit, never reset
        logic [7:0] tpage;           // Table page
        logic [7:0] vpage;           // Visibility page
        logic vis_en;                // Visibility enable
        logic [1:0] trap_flags;      // Sticky fault causes
        stack_state_type sk_state;   // Stack sequencer
        logic [15:0] pc_hi;          // Pending upper push word
        logic [15:0] rdata;          // Register read data
        logic [15:0] stk_addr, stk_wdata; // Stack memory address and data
        logic stk_wr, stk_rd, trap; // Stack strobes and trap pulse
        prog_state_type pm_state; // Program port sequencer
        logic take_table; // Pending read belongs to a table access
        logic take_high, take_byte, take_sel; // Lane choice of the pending read
        logic [23:0] paddr, pwdata; // Program port address and write data
        logic prd, pwr, pcfg, refused; // Program port strobes and flags
        logic [2:0] pstrb; // Write lane strobes
        logic [15:0] tbl_rdata, psv_rdata; // Read results
        logic tbl_rvalid, psv_rvalid, psv_stall; // Read result pulses
    } state_type;
    state_type q, d;

    logic remap_hit;          // Data read lands in the enabled window
    logic [23:0] mapped_addr; // Address from the mapper
    logic mapped_cfg;         // Mapper says configuration space

    // Overflow means above the limit, so a push at the limit itself is fine
    function automatic logic over_limit(input logic [15:0] addr, input logic [15:0] lim);
        over_limit = addr > lim;
    endfunction

    // Underflow means below the floor
    function automatic logic under_floor(input logic [15:0] addr);
        under_floor = addr < STACK_FLOOR;
    endfunction

    assign remap_hit = data_rd_in && data_ea_in[EA_REMAP_BIT] && q.vis_en;

    // Remapping is suspended while a table access is asked for
    program_space_mapper u_mapper (
        .table_access_in(table_req_in),
        .table_page_in(q.tpage),
        .visibility_page_in(q.vpage),
        .effective_addr_in(table_req_in ? table_ea_in : data_ea_in),
        .prog_addr_out(mapped_addr),
        .config_space_out(mapped_cfg)
    );

    // Next state of the whole block
    always_comb begin
        logic [15:0] ea, lim_wr;
        logic fault_over, fault_under;
        ea = 16'h0000;
        fault_over = 1'b0;
        fault_under = 1'b0;
        lim_wr = {reg_wdata_in[15:1], 1'b0};
        d = q;
        // Pulses default low
        {d.stk_wr, d.stk_rd, d.trap, d.prd, d.pwr, d.refused} = 6'h00;
        {d.tbl_rvalid, d.psv_rvalid, d.psv_stall} = 3'h0;
        // Stack sequencer
        case (q.sk_state)
            SK_IDLE: begin
                if (push_in || call_push_in || exc_push_in) begin
                    ea = q.sp;
                    d.stk_addr = q.sp;
                    d.stk_wr = 1'b1;
                    d.sp = q.sp + STACK_STEP;
                    if (push_in) begin
                        d.stk_wdata = push_data_in;
                    end else begin
                        // Low counter word goes first, upper part next cycle
                        d.stk_wdata = program_counter_in[15:0];
                        d.sk_state = SK_PUSH_HI;
                    end
                    d.pc_hi = {exc_push_in ? status_low_byte_in : 8'h00, 1'b0,
                               program_counter_in[22:16]};
                end else if (pop_in) begin
                    ea = q.sp - STACK_STEP;
                    d.stk_addr = ea;
                    d.stk_rd = 1'b1;
                    d.sp = ea;
                end else if (sp_ea_valid_in) begin
                    // Other addressing through the stack pointer is checked too
                    ea = sp_ea_in;
                end
            end
            SK_PUSH_HI: begin
                // Second word of a counter push, new requests in this cycle are dropped
                ea = q.sp;
                d.stk_addr = q.sp;
                d.stk_wdata = q.pc_hi;
                d.stk_wr = 1'b1;
                d.sp = q.sp + STACK_STEP;
                d.sk_state = SK_IDLE;
            end
            default: begin
                d.sk_state = SK_IDLE;
            end
        endcase

        // Check every stack address formed this cycle
        if (q.sk_state == SK_PUSH_HI || push_in || call_push_in || exc_push_in
            || pop_in || sp_ea_valid_in) begin
            fault_over = over_limit(ea, q.limit);
            fault_under = under_floor(ea);
        end
        d.trap = fault_over || fault_under;

        // Program memory sequencer
        case (q.pm_state)
            PM_IDLE: begin
                d.paddr = mapped_addr;
                d.pcfg = mapped_cfg;
                if (table_req_in) begin
                    {d.take_table, d.take_high, d.take_byte, d.take_sel} =
                        {1'b1, table_high_in, table_byte_in, table_ea_in[0]};
                    if (table_write_in) begin
                        if (mapped_cfg) begin
                            d.refused = 1'b1;
                        end else begin
                            d.pwr = 1'b1;
                            d.pstrb = lane_strobe(table_high_in, table_byte_in, table_ea_in[0]);
                            d.pwdata = lane_data(table_high_in || table_byte_in, table_wdata_in);
                        end
                    end else begin
                        d.prd = 1'b1;
                        d.pm_state = PM_WAIT;
                    end
                end else if (remap_hit) begin
                    d.take_table = 1'b0;
                    d.prd = 1'b1;
                    d.psv_stall = 1'b1;
                    d.pm_state = PM_PSV_SECOND;
                end
            end
            PM_PSV_SECOND: begin
                d.prd = 1'b1;
                d.psv_stall = 1'b1;
                d.pm_state = PM_WAIT;
            end
            PM_WAIT: begin
                d.pm_state = PM_TAKE;
            end
            PM_TAKE: begin
                if (q.take_table) begin
                    d.tbl_rdata = read_lane(q.take_high, q.take_byte, q.take_sel, prog_rdata_in);
                    d.tbl_rvalid = 1'b1;
                end else begin
                    d.psv_rdata = prog_rdata_in[15:0];
                    d.psv_rvalid = 1'b1;
                end
                d.pm_state = PM_IDLE;
            end
            default: begin
                d.pm_state = PM_IDLE;
            end
        endcase

        // Register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_STACK_POINTER: d.sp = {reg_wdata_in[15:1], 1'b0};
                REG_STACK_LIMIT: d.limit = lim_wr;
                REG_TABLE_PAGE: d.tpage = reg_wdata_in[7:0];
                REG_VISIBILITY_PAGE: d.vpage = reg_wdata_in[7:0];
                REG_CPU_CONTROL: d.vis_en = reg_wdata_in[VIS_ENABLE_BIT];
                // Write one to clear a cause
                REG_TRAP_STATUS: d.trap_flags = q.trap_flags & ~reg_wdata_in[1:0];
                default: ;
            endcase
        end
        // Fresh faults win over a clear in the same cycle
        d.trap_flags[TRAP_OVER_BIT] = d.trap_flags[TRAP_OVER_BIT] | fault_over;
        d.trap_flags[TRAP_UNDER_BIT] = d.trap_flags[TRAP_UNDER_BIT] | fault_under;

        // Register reads, data stand the next cycle only
        d.rdata = 16'h0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_STACK_POINTER: d.rdata = q.sp;
                REG_STACK_LIMIT: d.rdata = {q.limit[15:1], 1'b0};
                REG_TABLE_PAGE: d.rdata = {8'h00, q.tpage};
                REG_VISIBILITY_PAGE: d.rdata = {8'h00, q.vpage};
                REG_CPU_CONTROL: d.rdata = 16'(q.vis_en) << VIS_ENABLE_BIT;
                REG_TRAP_STATUS: d.rdata = {14'h0000, q.trap_flags};
                default: d.rdata = 16'h0000;
            endcase
        end
        // Reset, the stack limit keeps whatever it holds
        if (sys_rst_in) begin
            // limit left alone; idle states are the first enum values, so zero
            d = '0;
            d.limit = q.limit;
            d.sp = STACK_POINTER_RESET;
            d.tpage = TABLE_PAGE_RESET;
            d.vpage = VISIBILITY_PAGE_RESET;
        end
    end

    // Byte lanes of a table write; the high phantom byte has no storage
    function automatic logic [2:0] lane_strobe(input logic hi, input logic byt, input logic sel);
        if (hi) begin
            lane_strobe = (byt && sel) ? 3'h0 : 3'h4;
        end else begin
            lane_strobe = byt ? (sel ? 3'h2 : 3'h1) : 3'h3;
        end
    endfunction
    // A byte is copied onto every lane, so the strobes alone pick where it lands
    function automatic logic [23:0] lane_data(input logic byte_wide, input logic [15:0] w);
        lane_data = byte_wide ? {3{w[7:0]}} : {8'h00, w};
    endfunction
    // Pick a table read result; the phantom byte always reads zero
    function automatic logic [15:0] read_lane(input logic hi, input logic byt, input logic sel,
                                              input logic [23:0] p);
        if (hi) begin
            read_lane = (byt && sel) ? 16'h0000 : {8'h00, p[23:16]};
        end else begin
            read_lane = byt ? {8'h00, sel ? p[15:8] : p[7:0]} : p[15:0];
        end
    endfunction

    // The one state register
    always_ff @(posedge clock_in) begin
        q <= d;
    end
    // Outputs straight from the state register
    assign {reg_rdata_out, stack_addr_out, stack_wdata_out, stack_wr_out, stack_rd_out} =
        {q.rdata, q.stk_addr, q.stk_wdata, q.stk_wr, q.stk_rd};
    assign {stack_pointer_out, stack_trap_out, table_rdata_out, table_rvalid_out} =
        {q.sp, q.trap, q.tbl_rdata, q.tbl_rvalid};
    assign {table_refused_out, remap_rdata_out, remap_rvalid_out, remap_stall_out} =
        {q.refused, q.psv_rdata, q.psv_rvalid, q.psv_stall};
    assign {prog_addr_out, prog_rd_out, prog_wr_out, prog_wdata_out, prog_wstrb_out} =
        {q.paddr, q.prd, q.pwr, q.pwdata, q.pstrb};
    assign prog_config_out = q.pcfg;

endmodule

`default_nettype wire

// ### core/stack_map_pkg.sv
package stack_map_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] REG_STACK_POINTER = 4'h0;
    localparam logic [3:0] REG_STACK_LIMIT = 4'h1;
    localparam logic [3:0] REG_TABLE_PAGE = 4'h2;
    localparam logic [3:0] REG_VISIBILITY_PAGE = 4'h3;
    localparam logic [3:0] REG_CPU_CONTROL = 4'h4;
    localparam logic [3:0] REG_TRAP_STATUS = 4'h5;

    // Field positions
    localparam int VIS_ENABLE_BIT = 2;
    localparam int TRAP_OVER_BIT = 0;
    localparam int TRAP_UNDER_BIT = 1;
    localparam int CFG_SPACE_BIT = 7;
    localparam int EA_REMAP_BIT = 15;

    // Reset values
    localparam logic [15:0] STACK_POINTER_RESET = 16'h0800;
    localparam logic [7:0] TABLE_PAGE_RESET = 8'h00;
    localparam logic [7:0] VISIBILITY_PAGE_RESET = 8'h00;

    // Lowest legal stack address, keeps the stack above special registers
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    // Stack pointer step, one data word
    localparam logic [15:0] STACK_STEP = 16'h0002;

    // Stack sequencer states
    typedef enum logic [0:0] {SK_IDLE, SK_PUSH_HI} stack_state_type;
    // Program memory port states
    typedef enum logic [1:0] {PM_IDLE, PM_PSV_SECOND, PM_WAIT, PM_TAKE} prog_state_type;

endpackage

// ### core/program_space_mapper.sv
`timescale 1ns/1ps
`default_nettype none

module program_space_mapper
    import stack_map_pkg::*;
(
    input wire logic table_access_in,
    input wire logic [7:0] table_page_in,
    input wire logic [7:0] visibility_page_in,
    input wire logic [15:0] effective_addr_in,
    output logic [23:0] prog_addr_out,
    output logic config_space_out
);

    // Address construction, table accesses take precedence over remapping
    always_comb begin
        if (table_access_in) begin
            prog_addr_out = {table_page_in, effective_addr_in};
            config_space_out = table_page_in[CFG_SPACE_BIT];
        end else begin
            prog_addr_out = {1'b0, visibility_page_in, effective_addr_in[14:0]};
            config_space_out = 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### sim/stack_map_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module stack_map_asserts
    import stack_map_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic call_push_in,
    input wire logic exc_push_in,
    input wire logic [22:0] program_counter_in,
    input wire logic [7:0] status_low_byte_in,
    input wire logic [15:0] stack_addr_out,
    input wire logic [15:0] stack_wdata_out,
    input wire logic stack_wr_out,
    input wire logic stack_rd_out,
    input wire logic [15:0] stack_pointer_out,
    input wire logic stack_trap_out,
    input wire logic table_req_in,
    input wire logic table_write_in,
    input wire logic [15:0] table_ea_in,
    input wire logic [15:0] data_ea_in,
    input wire logic remap_stall_out,
    input wire logic remap_rvalid_out,
    input wire logic table_refused_out,
    input wire logic [23:0] prog_addr_out,
    input wire logic prog_rd_out,
    input wire logic prog_wr_out,
    input wire logic prog_config_out
);
    // High when the second word of a counter push owns the cycle
    logic hold_q;

    // Requests in that cycle are dropped, so they must not arm checks
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            hold_q <= 1'h0;
        end else begin
            hold_q <= (call_push_in | exc_push_in) & ~push_in & ~hold_q;
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    a_push_post_inc: assert property (push_in && !hold_q |=> stack_wr_out
        && stack_addr_out == $past(stack_pointer_out) && stack_pointer_out == stack_addr_out + 16'h2)
        else $error("push address or pointer step wrong");
    a_pop_pre_dec: assert property (pop_in && !push_in && !call_push_in && !exc_push_in
        && !hold_q |=> stack_rd_out && stack_addr_out == $past(stack_pointer_out) - 16'h2
        && stack_pointer_out == stack_addr_out)
        else $error("pop address or pointer step wrong");
    a_call_zero_ext: assert property (call_push_in && !push_in && !hold_q |=>
        stack_wr_out && stack_wdata_out == $past(program_counter_in[15:0]) ##1
        stack_wr_out && stack_wdata_out == {9'h0, $past(program_counter_in[22:16], 2)})
        else $error("call push words wrong");
    a_exc_status_word: assert property (exc_push_in && !push_in && !call_push_in
        && !hold_q |=> ##1 stack_wr_out
        && stack_wdata_out == {$past(status_low_byte_in, 2), 1'h0,
        $past(program_counter_in[22:16], 2)})
        else $error("exception push high word wrong");
    a_floor_trap: assert property (push_in && !hold_q && stack_pointer_out < STACK_FLOOR
        |=> stack_trap_out)
        else $error("push below floor did not trap");
    a_table_addr: assert property (table_req_in && !table_write_in |=>
        prog_rd_out && prog_addr_out[15:0] == $past(table_ea_in))
        else $error("table read address wrong");
    a_remap_fetch: assert property ($rose(remap_stall_out) |-> prog_rd_out
        && !prog_config_out && !prog_addr_out[23]
        && prog_addr_out[14:0] == $past(data_ea_in[14:0])
        ##1 remap_stall_out && prog_rd_out ##1 !remap_stall_out ##1 remap_rvalid_out)
        else $error("remapped read sequence wrong");
    a_config_write: assert property (table_req_in && table_write_in |=>
        (prog_wr_out ^ table_refused_out) && !(prog_wr_out && prog_config_out))
        else $error("table write outcome wrong");

    c_call: cover property (call_push_in && !hold_q);
    c_refused: cover property (table_refused_out);
    c_remap: cover property ($rose(remap_stall_out));
endmodule

bind stack_check_and_program_space_map stack_map_asserts i_stack_map_asserts (.*);

`default_nettype wire

// ### sim/prog_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module prog_mem_model (
    input wire logic clock_in,
    input wire logic rd_in,
    input wire logic [23:0] addr_in,
    output logic [23:0] rdata_out
);
    // Returned word, a pattern of the low 16 address bits, so locations differing only above bit 15 match
    logic [23:0] q = 24'h0;
    assign rdata_out = q;

    always @(posedge clock_in) begin
        if (rd_in) begin
            q <= {addr_in[7:0] ^ 8'ha5, addr_in[15:0] ^ 16'h3c3c};
        end else begin
            // Stale data is inverted every cycle so a sample one cycle late does not match
            q <= ~q;
        end
    end
endmodule

`default_nettype wire

// ### sim/test_stack_check_and_program_space_map.sv
`timescale 1ns/1ps
`default_nettype none

module test_stack_check_and_program_space_map
    import stack_map_pkg::*;
;
    // Inputs, all defined at time zero
    logic clock_in = '0, sys_rst_in = 1'h1;
    logic [3:0] reg_addr_in = '0;
    logic [15:0] reg_wdata_in = '0, push_data_in = '0, sp_ea_in = '0;
    logic [15:0] table_ea_in = '0, table_wdata_in = '0, data_ea_in = '0;
    logic reg_wr_in = '0, reg_rd_in = '0, push_in = '0, pop_in = '0;
    logic call_push_in = '0, exc_push_in = '0, sp_ea_valid_in = '0;
    logic table_req_in = '0, table_write_in = '0, table_high_in = '0;
    logic table_byte_in = '0, data_rd_in = '0;
    logic [22:0] program_counter_in = '0;
    logic [7:0] status_low_byte_in = '0;
    // Outputs
    logic [23:0] prog_rdata_in, prog_addr_out, prog_wdata_out;
    logic [15:0] reg_rdata_out, stack_addr_out, stack_wdata_out, stack_pointer_out;
    logic [15:0] table_rdata_out, remap_rdata_out;
    logic stack_wr_out, stack_rd_out, stack_trap_out, table_rvalid_out, table_refused_out;
    logic remap_rvalid_out, remap_stall_out, prog_rd_out, prog_wr_out, prog_config_out;
    logic [2:0] prog_wstrb_out;
    // Scratch for expectations
    logic [7:0] page;
    logic [15:0] s;
    logic [23:0] a, w;
    int mismatches = 0, check_count = 0;

    always #5 clock_in = ~clock_in;

    stack_check_and_program_space_map i_stack_check_and_program_space_map (.*);
    prog_mem_model i_prog_mem_model (.clock_in(clock_in), .rd_in(prog_rd_out),
        .addr_in(prog_addr_out), .rdata_out(prog_rdata_in));

    // Same address pattern as the memory model serves
    function automatic logic [23:0] word_at(input logic [23:0] p);
        return {p[7:0] ^ 8'ha5, p[15:0] ^ 16'h3c3c};
    endfunction

    // Table read result: low space, or upper byte with its empty phantom byte
    function automatic logic [15:0] read_val(input logic h, b, e, input logic [23:0] p);
        if (!h) return b ? {8'h0, e ? p[15:8] : p[7:0]} : p[15:0];
        return (b && e) ? 16'h0 : {8'h0, p[23:16]};
    endfunction

    function automatic logic [2:0] lane(input logic h, b, e);
        return h ? 3'h4 : (b ? (e ? 3'h2 : 3'h1) : 3'h3);
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clock_in);
        reg_wr_in <= 1'h1;
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'h0;
    endtask

    // Read data is looked at in the one cycle after the strobe
    task automatic reg_read(input logic [3:0] ad, input logic [15:0] e);
        @(posedge clock_in);
        reg_rd_in <= 1'h1;
        reg_addr_in <= ad;
        @(posedge clock_in);
        reg_rd_in <= 1'h0;
        #1 chk({8'h0, reg_rdata_out}, {8'h0, e});
    endtask

    // k = push, pop, call, exception, checked address; ends in the answer cycle
    task automatic stack_op(input logic [4:0] k, input logic [15:0] d);
        @(posedge clock_in);
        {push_in, pop_in, call_push_in, exc_push_in, sp_ea_valid_in} <= k;
        push_data_in <= d;
        sp_ea_in <= d;
        @(posedge clock_in);
        {push_in, pop_in, call_push_in, exc_push_in, sp_ea_valid_in} <= 5'h0;
        #1;
    endtask

    task automatic stack_is(input logic [2:0] f, input logic [15:0] ad, input logic [15:0] sp);
        chk({5'h0, stack_wr_out, stack_rd_out, stack_trap_out, stack_addr_out}, {5'h0, f, ad});
        chk({8'h0, stack_pointer_out}, {8'h0, sp});
    endtask

    task automatic word_is(input logic [15:0] ad, input logic [15:0] d);
        chk({7'h0, stack_wr_out, stack_addr_out}, {8'h1, ad});
        chk({8'h0, stack_wdata_out}, {8'h0, d});
    endtask

    // m = write, upper space, byte; ends in the cycle after the request
    task automatic tbl(input logic [2:0] m, input logic [15:0] ea);
        @(posedge clock_in);
        {table_req_in, table_write_in, table_high_in, table_byte_in} <= {1'h1, m};
        table_ea_in <= ea;
        table_wdata_in <= ~ea;
        @(posedge clock_in);
        table_req_in <= 1'h0;
        #1;
    endtask

    task automatic remap(input logic [15:0] ea);
        @(posedge clock_in);
        data_rd_in <= 1'h1;
        data_ea_in <= ea;
        @(posedge clock_in);
        data_rd_in <= 1'h0;
        #1;
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    initial begin
        repeat (12) @(posedge clock_in);
        sys_rst_in <= 1'h0;
        reg_read(REG_STACK_POINTER, STACK_POINTER_RESET);
        reg_read(4'hf, 16'h0);
        reg_write(REG_STACK_LIMIT, 16'h0805);
        reg_read(REG_STACK_LIMIT, 16'h0804);
        // Up to the limit: the push at the limit passes, the next one traps
        for (s = 16'h0800; s < 16'h0808; s += 16'h2) begin
            stack_op(5'h10, s);
            stack_is({2'h2, s == 16'h0806}, s, s + 16'h2);
            chk({8'h0, stack_wdata_out}, {8'h0, s});
        end
        wait_cycles(1);
        chk({23'h0, stack_trap_out}, 24'h0);
        reg_write(REG_STACK_LIMIT, 16'hfffe);
        stack_op(5'h08, 16'h0);
        stack_is(3'h2, 16'h0806, 16'h0806);
        // Odd pointer write lands word aligned at the floor, then underflow
        reg_write(REG_STACK_POINTER, 16'h0801);
        reg_read(REG_STACK_POINTER, 16'h0800);
        stack_op(5'h08, 16'h0);
        stack_is(3'h3, 16'h07fe, 16'h07fe);
        stack_op(5'h10, 16'h0);
        stack_is(3'h5, 16'h07fe, 16'h0800);
        stack_op(5'h01, 16'h07fe);
        chk({23'h0, stack_trap_out}, 24'h1);
        stack_op(5'h01, 16'h0800);
        chk({23'h0, stack_trap_out}, 24'h0);
        reg_read(REG_TRAP_STATUS, 16'h0003);
        // Counter pushes: low word first, then the extended upper part
        reg_write(REG_STACK_POINTER, 16'h1000);
        program_counter_in <= 23'h7abcde;
        status_low_byte_in <= 8'hc3;
        stack_op(5'h04, 16'h0);
        word_is(16'h1000, 16'hbcde);
        wait_cycles(1);
        word_is(16'h1002, 16'h007a);
        stack_op(5'h02, 16'h0);
        word_is(16'h1004, 16'hbcde);
        wait_cycles(1);
        word_is(16'h1006, 16'hc37a);
        chk({8'h0, stack_pointer_out}, 24'h001008);
        // Every table read mode in user and in configuration space
        for (int j = 0; j < 2; j++) begin
            page = j ? 8'h80 : 8'h12;
            reg_write(REG_TABLE_PAGE, {8'h0, page});
            for (int m = 0; m < 8; m++) begin
                if (m[1:0] == 2'h1) continue;
                a = {page, 15'h1a2b, m[0]};
                w = word_at(a);
                tbl({1'h0, m[2:1]}, a[15:0]);
                chk({prog_rd_out, prog_config_out, 22'h0}, {1'h1, page[7], 22'h0});
                chk(prog_addr_out, a);
                wait_cycles(2);
                chk({7'h0, table_rvalid_out, table_rdata_out},
                    {8'h1, read_val(m[2], m[1], m[0], w)});
            end
        end
        // Writes reach each byte lane in user space
        reg_write(REG_TABLE_PAGE, 16'h0012);
        for (int m = 0; m < 7; m++) begin
            if (m[1:0] == 2'h1) continue;
            tbl({1'h1, m[2:1]}, {15'h0040, m[0]});
            chk({prog_wr_out, table_refused_out, 19'h0, prog_wstrb_out},
                {2'h2, 19'h0, lane(m[2], m[1], m[0])});
            chk(prog_addr_out, {8'h12, 15'h0040, m[0]});
            // Only the strobed lanes must carry the written byte or word
            page = {5'h0, lane(m[2], m[1], m[0])};
            w = {{8{page[2]}}, {8{page[1]}}, {8{page[0]}}};
            s = ~{15'h0040, m[0]};
            chk(prog_wdata_out & w, ((m[2] || m[1]) ? {3{s[7:0]}} : {8'h0, s}) & w);
        end
        reg_write(REG_TABLE_PAGE, 16'h0080);
        tbl(3'h4, 16'h0040);
        chk({prog_wr_out, table_refused_out, 22'h0}, {2'h1, 22'h0});
        // Remapped reads: off while disabled, or with the top address bit clear
        reg_write(REG_VISIBILITY_PAGE, 16'h005a);
        remap(16'h9234);
        chk({prog_rd_out, remap_stall_out, 22'h0}, 24'h0);
        reg_write(REG_CPU_CONTROL, 16'h0004);
        remap(16'h1234);
        chk({prog_rd_out, remap_stall_out, 22'h0}, 24'h0);
        for (int j = 0; j < 2; j++) begin
            page = j ? 8'hff : 8'h5a;
            reg_write(REG_VISIBILITY_PAGE, {8'h0, page});
            a = {1'h0, page, 15'h1234};
            w = word_at(a);
            remap(16'h9234);
            chk({prog_rd_out, remap_stall_out, prog_config_out, 21'h0}, {3'h6, 21'h0});
            chk(prog_addr_out, a);
            wait_cycles(1);
            chk({22'h0, prog_rd_out, remap_stall_out}, 24'h3);
            wait_cycles(1);
            chk({22'h0, remap_rvalid_out, remap_stall_out}, 24'h0);
            wait_cycles(1);
            chk({7'h0, remap_rvalid_out, remap_rdata_out}, {8'h1, w[15:0]});
        end
        summarize();
    end

    // The sequence needs about 150 cycles; far beyond that it is hung
    initial begin
        repeat (20000) @(posedge clock_in);
        mismatches++;
        summarize();
    end
endmodule

`default_nettype wire
